// File: core/tcsync_map.vh
// Purpose: Constants for the time code sync and holdover control block
// Assumes: 40 MHz system clock
// Notes: Status codes are presented on status_out
`ifndef TCSYNC_MAP_VH
`define TCSYNC_MAP_VH
`define CLK_HZ 40000000
`define CYC_PER_SEC 32'd40000000
`define DRIFT_LIMIT_NS 1000
`define ST_FREEWHEEL 2'h0
`define ST_SYNC 2'h1
`define ST_HOLDOVER 2'h2
`define FMT_AM 1'b0
`define FMT_DCLS 1'b1
`define RESYNC_GOOD 4'h2
`define TRIM_MAX 16'h03e8
`endif

// File: core/day_calendar.v
// Purpose: Full date keeper: year and day of year, advanced on a day tick
// Assumes: Leap year is every fourth year, enough for 2001..2099
// Notes: Load has priority over advance
`timescale 1ns/1ps
module day_calendar
(
  input wire clk_in,
  input wire nrst_in,
  input wire load_in,
  input wire [6:0] year_in,
  input wire [8:0] doy_in,
  input wire advance_in,
  output reg [6:0] year_out,
  output reg [8:0] doy_out
);
  wire [8:0] last_day;
  assign last_day = (year_out[1:0] == 2'h0) ? 9'h16e : 9'h16d;
  // Hold and step the date
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      year_out <= 7'h00;
      doy_out <= 9'h001;
    end
    else if (load_in)
    begin
      year_out <= year_in;
      doy_out <= doy_in;
    end
    else if (advance_in)
    begin
      if (doy_out >= last_day)
      begin
        doy_out <= 9'h001;
        year_out <= year_out + 7'h01;
      end
      else
        doy_out <= doy_out + 9'h001;
    end
  end
endmodule

// File: core/tc_sync_ctrl.v
// Purpose: Sync, holdover and freewheel control for a time code receiver
// Assumes: A decoder upstream delivers telegram fields with a frame strobe
// Notes: Time of day kept in seconds of day; date in day_calendar
// Behaviour
// - Align clocks on good frames outside freewheel; enter sync only after consistency check passes
// - Telegram error in sync puts clock into holdover
// - Trim crystal to keep drift within 1us/s
// - Keep full date in local clocks
// - Compare received day of year every second
// - Date mismatch: holdover unless it comes with a time jump in sync, still discipline time base
// - Set clock to received time, offset separately
// - Time jump in sync causes freewheel, then resynchronise
// - Decode only the input chosen by format
`timescale 1ns/1ps
`include "tcsync_map.vh"
module tc_sync_ctrl
#(
  parameter CYC_SEC = `CYC_PER_SEC
)
(
  input wire clk_in,
  input wire nrst_in,
  input wire format_in,
  input wire am_code_input_in,
  input wire level_shift_code_input_in,
  input wire frame_valid_in,
  input wire frame_ok_in,
  input wire [16:0] frame_sec_in,
  input wire [8:0] frame_doy_in,
  input wire [15:0] phase_err_in,
  input wire date_load_in,
  input wire [6:0] date_year_in,
  input wire [8:0] date_doy_in,
  input wire [11:0] utc_offset_min_in,
  output reg selected_code_out,
  output reg [1:0] status_out,
  output reg [16:0] sec_of_day_out,
  output reg [6:0] year_out,
  output reg [8:0] doy_out,
  output reg [15:0] trim_out,
  output reg [11:0] utc_offset_out,
  output reg pps_out
);
  reg am_s1_reg, am_s2_reg, dc_s1_reg, dc_s2_reg;
  reg [31:0] div_reg;
  reg [16:0] sec_reg;
  reg [16:0] ref_sec_reg;
  reg [1:0] state_reg, state_next;
  reg [3:0] good_reg;
  reg day_tick_reg;
  reg sec_tick_reg;
  wire [6:0] cal_year;
  wire [8:0] cal_doy;
  wire date_match, jump, tel_good;
  wire [16:0] ref_exp;
  // Receiver conditions, same codes as status_out
  localparam [1:0] S_FREE = `ST_FREEWHEEL;
  localparam [1:0] S_SYNC = `ST_SYNC;
  localparam [1:0] S_HOLD = `ST_HOLDOVER;
  // Next value of the local second count, wrapping at the end of the day
  wire [16:0] sec_exp;
  assign sec_exp = (sec_reg == 17'h1517f) ? 17'h00000 : sec_reg + 17'h00001;
  // Continuity is judged against the last good telegram, not the local count,
  // so freewheel can see a continuous run and a late frame is no jump
  assign ref_exp = (ref_sec_reg == 17'h1517f) ? 17'h00000 : ref_sec_reg + 17'h00001;
  assign date_match = (frame_doy_in == cal_doy);
  assign jump = (frame_sec_in != ref_exp);
  assign tel_good = frame_valid_in && frame_ok_in;

  // Full date storage
  day_calendar u_cal
  (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .load_in(date_load_in),
    .year_in(date_year_in),
    .doy_in(date_doy_in),
    .advance_in(day_tick_reg),
    .year_out(cal_year),
    .doy_out(cal_doy)
  );

  // Pin synchronisers for both code inputs
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      am_s1_reg <= 1'b0;
      am_s2_reg <= 1'b0;
      dc_s1_reg <= 1'b0;
      dc_s2_reg <= 1'b0;
    end
    else
    begin
      am_s1_reg <= am_code_input_in;
      am_s2_reg <= am_s1_reg;
      dc_s1_reg <= level_shift_code_input_in;
      dc_s2_reg <= dc_s1_reg;
    end
  end

  // State selection: one branch per receiver condition
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      S_FREE:
      begin
        // Go to sync only after a run of continuous good frames; a good frame with a wrong day goes to holdover at once
        if (tel_good)
        begin
          if (!date_match)
            state_next = S_HOLD;
          else if (!jump && good_reg >= `RESYNC_GOOD)
            state_next = S_SYNC;
        end
      end
      S_SYNC:
      begin
        if (frame_valid_in && !frame_ok_in)
          state_next = S_HOLD;
        else if (tel_good && jump)
          state_next = S_FREE;
        else if (tel_good && !date_match)
          state_next = S_HOLD;
      end
      S_HOLD:
      begin
        // Back to sync once date and time agree for a run of frames
        if (tel_good && date_match && !jump && good_reg >= `RESYNC_GOOD)
          state_next = S_SYNC;
      end
      default:
        state_next = S_FREE;
    endcase
  end

  // Second of the last good telegram
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      ref_sec_reg <= 17'h00000;
    else if (tel_good)
      ref_sec_reg <= frame_sec_in;
  end

  // Run length of good, matching telegrams; a jump starts a new run
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      good_reg <= 4'h0;
    else if (tel_good && date_match)
    begin
      if (jump)
        good_reg <= 4'h1;
      else if (good_reg != 4'hf)
        good_reg <= good_reg + 4'h1;
    end
    else if (frame_valid_in)
      good_reg <= 4'h0;
  end

  // Second divider, time keeping, state and outputs
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      div_reg <= 32'h00000000;
      sec_reg <= 17'h00000;
      state_reg <= `ST_FREEWHEEL;
      day_tick_reg <= 1'b0;
      sec_tick_reg <= 1'b0;
      selected_code_out <= 1'b0;
      status_out <= `ST_FREEWHEEL;
      sec_of_day_out <= 17'h00000;
      year_out <= 7'h00;
      doy_out <= 9'h001;
      trim_out <= 16'h0000;
      utc_offset_out <= 12'h000;
      pps_out <= 1'b0;
    end
    else
    begin
      sec_tick_reg <= 1'b0;
      day_tick_reg <= 1'b0;
      state_reg <= state_next;
      // Only the chosen input reaches the decoder
      selected_code_out <= (format_in == `FMT_DCLS) ? dc_s2_reg : am_s2_reg;
      // Good frames outside freewheel set phase and time directly, offset kept as is
      if (tel_good && state_next != S_FREE)
      begin
        sec_reg <= frame_sec_in;
        div_reg <= 32'h00000000;
        // Discipline continues during date mismatch, clamped trim
        if (phase_err_in[15] && phase_err_in < (16'h0000 - `TRIM_MAX))
          trim_out <= 16'h0000 - `TRIM_MAX;
        else if (!phase_err_in[15] && phase_err_in > `TRIM_MAX)
          trim_out <= `TRIM_MAX;
        else
          trim_out <= phase_err_in;
      end
      else if (div_reg >= CYC_SEC - 32'd1)
      begin
        div_reg <= 32'h00000000;
        sec_tick_reg <= 1'b1;
        sec_reg <= sec_exp;
        if (sec_reg == 17'h1517f)
          day_tick_reg <= 1'b1;
      end
      else
        div_reg <= div_reg + 32'h00000001;
      pps_out <= sec_tick_reg;
      status_out <= state_reg;
      sec_of_day_out <= sec_reg;
      year_out <= cal_year;
      doy_out <= cal_doy;
      utc_offset_out <= utc_offset_min_in;
    end
  end
endmodule

// File: dv/tc_sync_props.sv
// Purpose: Port checks for tc_sync_ctrl
// Assumes: Status two edges after a frame
// Notes: Bound by name
`timescale 1ns/1ps
`include "tcsync_map.vh"
module tc_sync_props
(
  input wire clk_in,
  input wire nrst_in,
  input wire format_in,
  input wire am_code_input_in,
  input wire level_shift_code_input_in,
  input wire frame_valid_in,
  input wire frame_ok_in,
  input wire [8:0] frame_doy_in,
  input wire date_load_in,
  input wire [6:0] date_year_in,
  input wire [11:0] utc_offset_min_in,
  input wire selected_code_out,
  input wire [1:0] status_out,
  input wire [6:0] year_out,
  input wire [8:0] doy_out,
  input wire [15:0] trim_out,
  input wire [11:0] utc_offset_out,
  input wire pps_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Frame steps that must leave sync
  sequence bad_frame_s;
    frame_valid_in && !frame_ok_in;
  endsequence
  sequence wrong_day_s;
    frame_valid_in && frame_ok_in && frame_doy_in != doy_out && !date_load_in;
  endsequence
  bad_frame_a: assert property (bad_frame_s |-> ##2 status_out != `ST_SYNC)
    else $error("bad frame kept sync");
  wrong_day_a: assert property (wrong_day_s |-> ##2 status_out != `ST_SYNC)
    else $error("wrong day kept sync");
  trim_clamp_a: assert property ($signed(trim_out) <= 1000 && $signed(trim_out) >= -1000)
    else $error("trim out of range");
  status_code_a: assert property (status_out != 2'h3)
    else $error("status code undefined");
  code_select_a: assert property ($stable(format_in) [*3] |=> selected_code_out ==
    ($past(format_in) ? $past(level_shift_code_input_in, 3) : $past(am_code_input_in, 3)))
    else $error("wrong code input");
  offset_pass_a: assert property (nrst_in |=> utc_offset_out == $past(utc_offset_min_in))
    else $error("offset not passed");
  pps_pulse_a: assert property (pps_out |=> !pps_out)
    else $error("second pulse too long");
  date_load_a: assert property (date_load_in |-> ##2 year_out == $past(date_year_in, 2))
    else $error("year not loaded");
endmodule
bind tc_sync_ctrl tc_sync_props u_tc_sync_props (.*);

// File: dv/tc_source.sv
// Purpose: Time code source model
// Assumes: Decoded frames one cycle wide
// Notes: Second and day fields inverted after release
`timescale 1ns/1ps
module tc_source
(
  input wire clk_in,
  input wire nrst_in,
  output reg am_out,
  output reg lvl_out,
  output reg valid_out,
  output reg ok_out,
  output reg [16:0] sec_out,
  output reg [8:0] doy_out,
  output reg [15:0] phase_out
);
  reg [1:0] cnt_reg;
  initial valid_out = 1'b0;
  // Distinct patterns on the two code pins
  always @(posedge clk_in or negedge nrst_in)
    if (!nrst_in)
      cnt_reg <= 2'h0;
    else
      cnt_reg <= cnt_reg + 2'h1;
  always @*
  begin
    am_out = cnt_reg[1];
    lvl_out = cnt_reg[0];
  end
  // One decoded telegram with the given phase error
  task send(input ok, input [16:0] s, input [8:0] d, input [15:0] p);
    begin
      @(posedge clk_in);
      #1 {valid_out, ok_out, sec_out, doy_out, phase_out} = {1'b1, ok, s, d, p};
      @(posedge clk_in);
      #1 {valid_out, sec_out, doy_out} = {1'b0, ~s, ~d};
    end
  endtask
endmodule

// File: dv/tc_sync_ctrl_tb.sv
// Purpose: Scenario bench for tc_sync_ctrl
// Assumes: Short second of 1000 cycles
// Notes: Successive frames 44 cycles apart
`timescale 1ns/1ps
`include "tcsync_map.vh"
module tc_sync_ctrl_tb;
  reg clk_in = 0, nrst_in = 0, format_in = 0, date_load_in = 0;
  reg [6:0] date_year_in = 0;
  reg [8:0] date_doy_in = 0;
  reg [11:0] utc_offset_min_in = 0;
  wire am, lvl, fv, fok, sel, pps;
  wire [16:0] fsec, sec;
  wire [8:0] fdoy, doy;
  wire [15:0] ph, trim;
  wire [1:0] st;
  wire [6:0] yr;
  wire [11:0] ofs;
  int error_cnt = 0, compares = 0;
  always #12.5 clk_in = ~clk_in;
  tc_source u_tc_source (.clk_in(clk_in), .nrst_in(nrst_in), .am_out(am), .lvl_out(lvl),
    .valid_out(fv), .ok_out(fok), .sec_out(fsec), .doy_out(fdoy), .phase_out(ph));
  tc_sync_ctrl #(.CYC_SEC(1000)) u_tc_sync_ctrl (.clk_in(clk_in), .nrst_in(nrst_in),
    .format_in(format_in), .am_code_input_in(am), .level_shift_code_input_in(lvl),
    .frame_valid_in(fv), .frame_ok_in(fok), .frame_sec_in(fsec), .frame_doy_in(fdoy),
    .phase_err_in(ph), .date_load_in(date_load_in), .date_year_in(date_year_in),
    .date_doy_in(date_doy_in), .utc_offset_min_in(utc_offset_min_in),
    .selected_code_out(sel), .status_out(st), .sec_of_day_out(sec), .year_out(yr),
    .doy_out(doy), .trim_out(trim), .utc_offset_out(ofs), .pps_out(pps));
  task chk(input string nm, input [16:0] e, input [16:0] g);
    begin
      compares++;
      if (g !== e)
      begin
        error_cnt++;
        $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task give_verdict;
    begin
      if (error_cnt == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Frame, then wait until status has settled
  task fr(input ok, input [16:0] s, input [8:0] d, input [15:0] p);
    begin
      repeat (40) @(posedge clk_in);
      u_tc_source.send(ok, s, d, p);
      repeat (2) @(posedge clk_in);
      #1;
    end
  endtask
  task t_date;
    begin
      @(posedge clk_in);
      #1 {date_load_in, date_year_in, date_doy_in, utc_offset_min_in} = {1'b1, 7'h17, 9'h064, 12'h03c};
      @(posedge clk_in);
      #1 date_load_in = 0;
      @(posedge clk_in);
      #1 chk("year", 17'h17, yr);
      chk("doy", 17'h64, doy);
      chk("offset", 17'h3c, ofs);
    end
  endtask
  task t_sync(input [16:0] b, input [15:0] p, input [15:0] t);
    begin
      fr(1, b, 9'h064, p);
      fr(1, b + 1, 9'h064, p);
      chk("status two", `ST_FREEWHEEL, st);
      fr(1, b + 2, 9'h064, p);
      chk("status three", `ST_SYNC, st);
      chk("time", b + 2, sec);
      chk("trim", {1'b0, t}, trim);
    end
  endtask
  // Selected code output follows the chosen pin three edges later
  task t_sel;
    reg [2:0] hist;
    int i;
    begin
      hist = 3'h0;
      for (i = 0; i < 8; i++)
      begin
        @(posedge clk_in);
        #1;
        if (i > 2)
          chk("select", {16'h0000, hist[2]}, sel);
        hist = {hist[1:0], format_in ? lvl : am};
      end
    end
  endtask
  // One local second passes in holdover: one pulse, time steps by one
  task t_second;
    int i, n;
    begin
      n = 0;
      for (i = 0; i < 1100; i++)
      begin
        @(posedge clk_in);
        #1;
        if (pps)
          n++;
      end
      chk("pulses", 17'h00001, n[16:0]);
      chk("second", 17'h0002c, sec);
    end
  endtask
  initial
  begin
    #100000 error_cnt++;
    give_verdict;
  end
  initial
  begin
    repeat (8) @(posedge clk_in);
    #1 nrst_in = 1;
    t_date;
    t_sync(17'h0a, 16'h7530, 16'h03e8);
    t_sel;
    fr(1, 17'h14, 9'h064, 16'h0000);
    chk("jump", `ST_FREEWHEEL, st);
    format_in = 1;
    t_sync(17'h1e, 16'h8ad0, 16'hfc18);
    t_sel;
    fr(0, 17'h1f4, 9'h064, 16'h0000);
    chk("bad frame", `ST_HOLDOVER, st);
    chk("kept time", 17'h20, sec);
    chk("kept trim", 17'h0fc18, trim);
    nrst_in = 0;
    repeat (2) @(posedge clk_in);
    #1 nrst_in = 1;
    t_date;
    t_sync(17'h28, 16'h0123, 16'h0123);
    fr(1, 17'h2b, 9'h065, 16'h0064);
    chk("day mismatch", `ST_HOLDOVER, st);
    chk("time followed", 17'h2b, sec);
    chk("trim followed", 17'h00064, trim);
    t_second;
    give_verdict;
  end
endmodule
